/* verilog/spm_mode_switch.sv */
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
`include "spm_cfg.svh"
// Notes on behaviour
// - Select 0 (reset value) compares torque reference against torque level.
// - Select 1 compares speed reference, rotary or linear level by motor type.
// - Select 2 compares acceleration, rotary or linear level by motor type.
// - Select 3 compares position deviation against deviation level.
// - Select 4 disables automatic switching; no level is used.
// - Torque level 0 to 800 percent, reset value 200.
// - Torque mode: torque reference at or above level gives P control.
// - Rotary speed mode: speed at or above level (0..10000) gives P.
// - Linear speed mode: speed at or above level (0..10000) gives P.
// - Rotary accel mode: accel at or above level (0..30000) gives P.
// - Linear accel mode: accel at or above level (0..30000) gives P.
// - Deviation mode: deviation at or above level (0..10000) gives P.
// - Deviation condition acts only while in position control.
// - Position integral time constant 0 to 50000, reset value 0.
module spm_mode_switch #(
  parameter int REF_W = 32
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  // Drive state from the control core
  input wire logic linear_motor_in,
  input wire logic position_control_in,
  // References, signed, same clock
  input wire logic signed [REF_W-1:0] torque_ref_in,
  input wire logic signed [REF_W-1:0] speed_ref_in,
  input wire logic signed [REF_W-1:0] accel_ref_in,
  input wire logic signed [REF_W-1:0] pos_deviation_in,
  // Speed loop control
  output logic p_control_out,
  output spm_pkg::spm_pitc_t position_integral_time_constant_out
);
  import spm_pkg::*;

  spm_state_t st_ff;
  spm_state_t nxt_st;

  logic bus_req;
  logic wr_en;
  logic [31:0] wr_word;
  logic [`SPM_SEL_W-1:0] sel_lim;
  logic [`SPM_TRQ_W-1:0] trq_lim;
  logic [`SPM_SPD_W-1:0] rspd_lim;
  logic [`SPM_ACC_W-1:0] racc_lim;
  logic [`SPM_DEV_W-1:0] dev_lim;
  logic [`SPM_SPD_W-1:0] lspd_lim;
  logic [`SPM_ACC_W-1:0] lacc_lim;
  logic [`SPM_PITC_W-1:0] pitc_lim;
  logic [`SPM_NCMP-1:0][REF_W-1:0] cmp_val;
  logic [`SPM_NCMP-1:0][`SPM_THR_W-1:0] cmp_thr;
  logic [`SPM_NCMP-1:0] cmp_ge;
  logic p_req;

  // Byte-lane merge of a write into the current setting
  function automatic logic [31:0] merge_lanes(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0] lanes
  );
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        res[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Current contents of an address, zero when unmapped
  function automatic logic [31:0] reg_word(
    input spm_state_t s,
    input logic [7:0] adr,
    input logic lin,
    input logic pos
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (adr)
      `SPM_OFS_SEL: w = 32'(s.sel);
      `SPM_OFS_TRQ: w = 32'(s.trq);
      `SPM_OFS_RSPD: w = 32'(s.rspd);
      `SPM_OFS_RACC: w = 32'(s.racc);
      `SPM_OFS_DEV: w = 32'(s.dev);
      `SPM_OFS_LSPD: w = 32'(s.lspd);
      `SPM_OFS_LACC: w = 32'(s.lacc);
      `SPM_OFS_PITC: w = 32'(s.pitc);
      `SPM_OFS_STAT: begin
        w[`SPM_ST_PCTL] = s.pctl;
        w[`SPM_ST_LIN] = lin;
        w[`SPM_ST_POS] = pos;
        w[`SPM_ST_SEL_HI:`SPM_ST_SEL_LO] = s.sel;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // One request per ack; the ack itself blocks a double take
  assign bus_req = wb_cyc_in && wb_stb_in && !st_ff.ack;
  assign wr_en = bus_req && wb_we_in;
  assign wr_word = merge_lanes(
    reg_word(st_ff, wb_adr_in, linear_motor_in, position_control_in),
    wb_dat_in, wb_sel_in);

  // Out-of-range writes saturate rather than wrap
  spm_clamp #(
    .W(`SPM_SEL_W),
    .MAX(`SPM_SEL_MAX)
  ) u_clamp_sel (
    .val_in(wr_word),
    .val_out(sel_lim)
  );

  spm_clamp #(
    .W(`SPM_TRQ_W),
    .MAX(`SPM_TRQ_MAX)
  ) u_clamp_trq (
    .val_in(wr_word),
    .val_out(trq_lim)
  );

  spm_clamp #(
    .W(`SPM_SPD_W),
    .MAX(`SPM_SPD_MAX)
  ) u_clamp_rspd (
    .val_in(wr_word),
    .val_out(rspd_lim)
  );

  spm_clamp #(
    .W(`SPM_ACC_W),
    .MAX(`SPM_ACC_MAX)
  ) u_clamp_racc (
    .val_in(wr_word),
    .val_out(racc_lim)
  );

  spm_clamp #(
    .W(`SPM_DEV_W),
    .MAX(`SPM_DEV_MAX)
  ) u_clamp_dev (
    .val_in(wr_word),
    .val_out(dev_lim)
  );

  spm_clamp #(
    .W(`SPM_SPD_W),
    .MAX(`SPM_SPD_MAX)
  ) u_clamp_lspd (
    .val_in(wr_word),
    .val_out(lspd_lim)
  );

  spm_clamp #(
    .W(`SPM_ACC_W),
    .MAX(`SPM_ACC_MAX)
  ) u_clamp_lacc (
    .val_in(wr_word),
    .val_out(lacc_lim)
  );

  spm_clamp #(
    .W(`SPM_PITC_W),
    .MAX(`SPM_PITC_MAX)
  ) u_clamp_pitc (
    .val_in(wr_word),
    .val_out(pitc_lim)
  );

  // Comparator inputs; thresholds read live from the settings
  always_comb begin
    cmp_val = '0;
    cmp_thr = '0;
    cmp_val[`SPM_CMP_TRQ] = torque_ref_in;
    cmp_thr[`SPM_CMP_TRQ] = `SPM_THR_W'(st_ff.trq);
    cmp_val[`SPM_CMP_RSPD] = speed_ref_in;
    cmp_thr[`SPM_CMP_RSPD] = `SPM_THR_W'(st_ff.rspd);
    cmp_val[`SPM_CMP_LSPD] = speed_ref_in;
    cmp_thr[`SPM_CMP_LSPD] = `SPM_THR_W'(st_ff.lspd);
    cmp_val[`SPM_CMP_RACC] = accel_ref_in;
    cmp_thr[`SPM_CMP_RACC] = `SPM_THR_W'(st_ff.racc);
    cmp_val[`SPM_CMP_LACC] = accel_ref_in;
    cmp_thr[`SPM_CMP_LACC] = `SPM_THR_W'(st_ff.lacc);
    cmp_val[`SPM_CMP_DEV] = pos_deviation_in;
    cmp_thr[`SPM_CMP_DEV] = `SPM_THR_W'(st_ff.dev);
  end

  // Sign is ignored: braking counts the same as driving
  for (genvar g = 0; g < `SPM_NCMP; g++) begin : g_cmp
    spm_cmp #(
      .W(REF_W),
      .TW(`SPM_THR_W)
    ) u_cmp (
      .val_in(cmp_val[g]),
      .thr_in(cmp_thr[g]),
      .ge_out(cmp_ge[g])
    );
  end

  // Condition chosen by the select setting
  always_comb begin
    p_req = 1'b0;
    unique case (spm_sel_t'(st_ff.sel))
      SPM_SEL_TORQUE: begin
        p_req = cmp_ge[`SPM_CMP_TRQ];
      end
      SPM_SEL_SPEED: begin
        if (linear_motor_in) begin
          p_req = cmp_ge[`SPM_CMP_LSPD];
        end else begin
          p_req = cmp_ge[`SPM_CMP_RSPD];
        end
      end
      SPM_SEL_ACCEL: begin
        if (linear_motor_in) begin
          p_req = cmp_ge[`SPM_CMP_LACC];
        end else begin
          p_req = cmp_ge[`SPM_CMP_RACC];
        end
      end
      SPM_SEL_DEVIATION: begin
        // Deviation has no meaning outside position control
        p_req = cmp_ge[`SPM_CMP_DEV] && position_control_in;
      end
      SPM_SEL_NONE: begin
        p_req = 1'b0;
      end
      default: begin
        p_req = 1'b0;
      end
    endcase
  end

  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = bus_req;
    nxt_st.pctl = p_req;
    nxt_st.rdat = st_ff.rdat;
    if (bus_req) begin
      nxt_st.rdat = wb_we_in ? 32'h0000_0000 :
        reg_word(st_ff, wb_adr_in, linear_motor_in, position_control_in);
    end
    if (wr_en) begin
      unique case (wb_adr_in)
        `SPM_OFS_SEL: nxt_st.sel = sel_lim;
        `SPM_OFS_TRQ: nxt_st.trq = trq_lim;
        `SPM_OFS_RSPD: nxt_st.rspd = rspd_lim;
        `SPM_OFS_RACC: nxt_st.racc = racc_lim;
        `SPM_OFS_DEV: nxt_st.dev = dev_lim;
        `SPM_OFS_LSPD: nxt_st.lspd = lspd_lim;
        `SPM_OFS_LACC: nxt_st.lacc = lacc_lim;
        `SPM_OFS_PITC: nxt_st.pitc = pitc_lim;
        default: nxt_st.sel = st_ff.sel;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_ff.ack <= 1'b0;
      st_ff.rdat <= 32'h0000_0000;
      st_ff.sel <= `SPM_SEL_RST;
      st_ff.trq <= `SPM_TRQ_RST;
      st_ff.rspd <= `SPM_SPD_RST;
      st_ff.racc <= `SPM_ACC_RST;
      st_ff.dev <= `SPM_DEV_RST;
      st_ff.lspd <= `SPM_SPD_RST;
      st_ff.lacc <= `SPM_ACC_RST;
      st_ff.pitc <= `SPM_PITC_RST;
      st_ff.pctl <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_ack_out = st_ff.ack;
  assign wb_dat_out = st_ff.rdat;
  assign p_control_out = st_ff.pctl;
  assign position_integral_time_constant_out = st_ff.pitc;
endmodule // spm_mode_switch

/* verilog/spm_cfg.svh */
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH
// Register byte offsets
`define SPM_OFS_SEL 8'h00
`define SPM_OFS_TRQ 8'h04
`define SPM_OFS_RSPD 8'h08
`define SPM_OFS_RACC 8'h0c
`define SPM_OFS_DEV 8'h10
`define SPM_OFS_LSPD 8'h14
`define SPM_OFS_LACC 8'h18
`define SPM_OFS_PITC 8'h1c
`define SPM_OFS_STAT 8'h20
// Field widths
`define SPM_SEL_W 3
`define SPM_TRQ_W 10
`define SPM_SPD_W 14
`define SPM_ACC_W 15
`define SPM_DEV_W 14
`define SPM_PITC_W 16
`define SPM_THR_W 16
// Upper limits of each setting
`define SPM_SEL_MAX 32'h0000_0004
`define SPM_TRQ_MAX 32'h0000_0320
`define SPM_SPD_MAX 32'h0000_2710
`define SPM_ACC_MAX 32'h0000_7530
`define SPM_DEV_MAX 32'h0000_2710
`define SPM_PITC_MAX 32'h0000_c350
// Reset values
`define SPM_SEL_RST 3'h0
`define SPM_TRQ_RST 10'h0c8
`define SPM_SPD_RST 14'h0000
`define SPM_ACC_RST 15'h0000
`define SPM_DEV_RST 14'h0000
`define SPM_PITC_RST 16'h0000
// Status register bit positions
`define SPM_ST_PCTL 0
`define SPM_ST_LIN 1
`define SPM_ST_POS 2
`define SPM_ST_SEL_LO 4
`define SPM_ST_SEL_HI 6
// Comparator slots
`define SPM_NCMP 6
`define SPM_CMP_TRQ 0
`define SPM_CMP_RSPD 1
`define SPM_CMP_LSPD 2
`define SPM_CMP_RACC 3
`define SPM_CMP_LACC 4
`define SPM_CMP_DEV 5
`endif

/* verilog/spm_pkg.sv */
`include "spm_cfg.svh"
package spm_pkg;
  typedef enum logic [`SPM_SEL_W-1:0] {
    SPM_SEL_TORQUE,
    SPM_SEL_SPEED,
    SPM_SEL_ACCEL,
    SPM_SEL_DEVIATION,
    SPM_SEL_NONE
  } spm_sel_t;

  typedef logic [`SPM_PITC_W-1:0] spm_pitc_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [`SPM_SEL_W-1:0] sel;
    logic [`SPM_TRQ_W-1:0] trq;
    logic [`SPM_SPD_W-1:0] rspd;
    logic [`SPM_ACC_W-1:0] racc;
    logic [`SPM_DEV_W-1:0] dev;
    logic [`SPM_SPD_W-1:0] lspd;
    logic [`SPM_ACC_W-1:0] lacc;
    logic [`SPM_PITC_W-1:0] pitc;
    logic pctl;
  } spm_state_t;
endpackage

/* verilog/spm_clamp.sv */
`timescale 1ns/1ns
// Saturates a written word to the setting's upper limit
module spm_clamp #(
  parameter int W = 16,
  parameter logic [31:0] MAX = 32'h0000_ffff
) (
  // Raw word
  input wire logic [31:0] val_in,
  // Limited setting
  output logic [W-1:0] val_out
);
  always_comb begin
    if (val_in > MAX) begin
      val_out = MAX[W-1:0];
    end else begin
      val_out = val_in[W-1:0];
    end
  end
endmodule // spm_clamp

/* verilog/spm_cmp.sv */
`timescale 1ns/1ns
// Magnitude of a signed reference against an unsigned level
module spm_cmp #(
  parameter int W = 32,
  parameter int TW = 16
) (
  // Operands
  input wire logic signed [W-1:0] val_in,
  input wire logic [TW-1:0] thr_in,
  // Result
  output logic ge_out
);
  logic [W:0] mag;
  // Extra bit keeps the most negative value correct
  always_comb begin
    mag = {val_in[W-1], val_in};
    if (val_in[W-1]) begin
      mag = (W+1)'(-$signed(mag));
    end
    ge_out = mag >= (W+1)'(thr_in);
  end
endmodule // spm_cmp

/* sim/spm_chk.sv */
`timescale 1ns/1ns
module spm_chk (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Bus
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic wb_ack_out,
  input wire logic [31:0] wb_dat_out,
  // Control
  input wire logic position_control_in,
  input wire logic p_control_out,
  input wire spm_pkg::spm_pitc_t position_integral_time_constant_out
);
  import spm_pkg::*;
  logic [2:0] sel_sh_ff;
  logic take;
  assign take = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  // Shadow of select; full-lane writes only
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sel_sh_ff <= 3'h0;
    end else if (take && wb_we_in && wb_adr_in == 8'h00) begin
      sel_sh_ff <= (wb_dat_in > 32'h4) ? 3'h4 : wb_dat_in[2:0];
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence s_take;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_rd_unmapped;
    s_take ##0 (!wb_we_in && wb_adr_in > 8'h20);
  endsequence
  a_ack_after_take: assert property (s_take |=> wb_ack_out)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
    else $error("ack without request");
  a_unmapped_zero: assert property (s_rd_unmapped |=> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
  a_dat_holds: assert property (!take |=> $stable(wb_dat_out))
    else $error("read data moved without request");
  a_none_keeps_pi: assert property (sel_sh_ff == 3'h4 |=> !p_control_out)
    else $error("switching while disabled");
  a_dev_pos_only: assert property (sel_sh_ff == 3'h3 && !position_control_in
    |=> !p_control_out)
    else $error("deviation used outside position control");
  a_pitc_holds: assert property (!(take && wb_we_in && wb_adr_in == 8'h1c)
    |=> $stable(position_integral_time_constant_out))
    else $error("time constant moved without write");
  a_reset_clears: assert property (disable iff (1'b0) rst_in
    |=> !p_control_out && position_integral_time_constant_out == 16'h0)
    else $error("outputs not cleared by reset");
endmodule // spm_chk
bind spm_mode_switch spm_chk spm_chk_inst (.mclk_in, .rst_in, .wb_cyc_in, .wb_stb_in,
  .wb_we_in, .wb_adr_in, .wb_dat_in, .wb_ack_out, .wb_dat_out, .position_control_in,
  .p_control_out, .position_integral_time_constant_out);

/* sim/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import spm_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wb_cyc_in = 1'b0;
  logic wb_stb_in = 1'b0;
  logic wb_we_in = 1'b0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [3:0] wb_sel_in = 4'hf;
  logic [31:0] wb_dat_in = 32'h0;
  logic wb_ack_out;
  logic [31:0] wb_dat_out;
  logic linear_motor_in = 1'b0;
  logic position_control_in = 1'b0;
  logic signed [31:0] torque_ref_in = 32'h0;
  logic signed [31:0] speed_ref_in = 32'h0;
  logic signed [31:0] accel_ref_in = 32'h0;
  logic signed [31:0] pos_deviation_in = 32'h0;
  logic p_control_out;
  spm_pitc_t position_integral_time_constant_out;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] rd;
  always #10 mclk_in = ~mclk_in;
  spm_mode_switch spm_mode_switch_inst (.mclk_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
    .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_ack_out, .wb_dat_out, .linear_motor_in,
    .position_control_in, .torque_ref_in, .speed_ref_in, .accel_ref_in, .pos_deviation_in,
    .p_control_out, .position_integral_time_constant_out);
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, far above the under two hundred cycles needed
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Entered just after a rising edge; leaves one idle cycle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= adr;
    wb_dat_in <= dat;
    do @(posedge mclk_in); while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    check(rd, exp, "register read");
  endtask
  // Decision is one edge behind its inputs
  task automatic probe(input logic lin, pos, input logic [31:0] t, s, a, d, input logic exp);
    linear_motor_in <= lin;
    position_control_in <= pos;
    torque_ref_in <= t;
    speed_ref_in <= s;
    accel_ref_in <= a;
    pos_deviation_in <= d;
    repeat (2) @(posedge mclk_in);
    check({31'h0, p_control_out}, {31'h0, exp}, "p control");
  endtask
  task automatic t_defaults;
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, 32'hc8);
    for (int i = 2; i < 8; i++) rdchk(8'(i * 4), 32'h0);
    rdchk(8'h30, 32'h0);
    probe(1'b0, 1'b0, 32'hc8, 32'h0, 32'h0, 32'h0, 1'b1);
    probe(1'b0, 1'b0, 32'hc7, 32'h0, 32'h0, 32'h0, 1'b0);
    $display("test defaults done");
  endtask
  task automatic t_torque;
    wb(1'b1, 8'h04, 32'h384);
    rdchk(8'h04, 32'h320);
    wb(1'b1, 8'h04, 32'h32);
    probe(1'b0, 1'b1, -32'sh32, 32'h0, 32'h0, 32'h0, 1'b1);
    probe(1'b0, 1'b1, 32'h31, 32'h2710, 32'h7530, 32'h2710, 1'b0);
    $display("test torque done");
  endtask
  task automatic t_speed;
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b1, 8'h08, 32'h3e8);
    wb(1'b1, 8'h14, 32'h1f4);
    probe(1'b0, 1'b0, 32'h320, 32'h3e7, 32'h0, 32'h0, 1'b0);
    probe(1'b0, 1'b0, 32'h0, 32'h3e8, 32'h0, 32'h0, 1'b1);
    probe(1'b1, 1'b0, 32'h0, 32'h3e7, 32'h0, 32'h0, 1'b1);
    probe(1'b1, 1'b0, 32'h0, 32'h1f3, 32'h0, 32'h0, 1'b0);
    wb(1'b1, 8'h08, 32'h4e20);
    rdchk(8'h08, 32'h2710);
    $display("test speed done");
  endtask
  task automatic t_accel;
    wb(1'b1, 8'h00, 32'h2);
    wb(1'b1, 8'h0c, 32'h7530);
    wb(1'b1, 8'h18, 32'h64);
    probe(1'b0, 1'b0, 32'h0, 32'h2710, 32'h752f, 32'h0, 1'b0);
    probe(1'b0, 1'b0, 32'h0, 32'h0, -32'sh7530, 32'h0, 1'b1);
    probe(1'b1, 1'b0, 32'h0, 32'h0, 32'h64, 32'h0, 1'b1);
    probe(1'b1, 1'b0, 32'h0, 32'h0, 32'h63, 32'h0, 1'b0);
    wb(1'b1, 8'h18, 32'h9c40);
    rdchk(8'h18, 32'h7530);
    $display("test accel done");
  endtask
  task automatic t_dev;
    wb(1'b1, 8'h00, 32'h3);
    wb(1'b1, 8'h10, 32'h32);
    probe(1'b0, 1'b1, 32'h0, 32'h0, 32'h0, 32'h32, 1'b1);
    // Status: P active, rotary, position control, select 3
    rdchk(8'h20, 32'h35);
    probe(1'b0, 1'b1, 32'h320, 32'h0, 32'h0, 32'h31, 1'b0);
    probe(1'b0, 1'b0, 32'h0, 32'h0, 32'h0, 32'h32, 1'b0);
    $display("test deviation done");
  endtask
  task automatic t_none;
    wb(1'b1, 8'h00, 32'h7);
    rdchk(8'h00, 32'h4);
    probe(1'b1, 1'b1, 32'h320, 32'h2710, 32'h7530, 32'h2710, 1'b0);
    wb(1'b1, 8'h00, 32'h0);
    probe(1'b0, 1'b0, 32'h320, 32'h0, 32'h0, 32'h0, 1'b1);
    $display("test disabled done");
  endtask
  task automatic t_pitc;
    wb(1'b1, 8'h1c, 32'hc350);
    check(32'(position_integral_time_constant_out), 32'hc350, "time const");
    wb(1'b1, 8'h1c, 32'hea60);
    check(32'(position_integral_time_constant_out), 32'hc350, "time const");
    wb(1'b1, 8'h1c, 32'h4d2);
    rdchk(8'h1c, 32'h4d2);
    // One lane only: upper byte replaces the stored upper byte, stored low byte kept
    wb_sel_in <= 4'h2;
    wb(1'b1, 8'h1c, 32'h0000ab00);
    wb_sel_in <= 4'hf;
    rdchk(8'h1c, 32'habd2);
    $display("test time constant done");
  endtask
  // Reset in mid-run while P control is active and settings are non-default
  task automatic t_reset;
    rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    check({31'h0, p_control_out}, 32'h0, "p control after reset");
    check(32'(position_integral_time_constant_out), 32'h0, "time const after reset");
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, 32'hc8);
    rdchk(8'h08, 32'h0);
    rdchk(8'h1c, 32'h0);
    probe(1'b0, 1'b0, 32'h320, 32'h0, 32'h0, 32'h0, 1'b1);
    $display("test reset done");
  endtask
  initial begin
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    t_defaults();
    t_torque();
    t_speed();
    t_accel();
    t_dev();
    t_none();
    t_pitc();
    t_reset();
    complete_run();
  end
endmodule // testbench
